// [spb_map.vh]
// address map, field layout and timing constants of the serial port block
`ifndef SPB_MAP_VH
`define SPB_MAP_VH

// ============================================================
// clock and oversampling
`define SPB_CLK_HZ        25000000
`define SPB_OVS           16
`define SPB_TICK_LAST     4'hF
`define SPB_TICK_HALF     4'h7
`define SPB_DIV_W         16

// ============================================================
// baud rate select codes and rates
`define SPB_SEL_EXT       4'h0
`define SPB_SEL_MAX       4'hA
`define SPB_BAUD_1        75
`define SPB_BAUD_2        110
`define SPB_BAUD_3        150
`define SPB_BAUD_4        200
`define SPB_BAUD_5        300
`define SPB_BAUD_6        600
`define SPB_BAUD_7        1200
`define SPB_BAUD_8        2400
`define SPB_BAUD_9        4800
`define SPB_BAUD_10       9600

// ============================================================
// chip enable window on address bits 15, 17 and 19
`define SPB_ADDR_W        20
`define SPB_CE_BIT_LO     15
`define SPB_CE_BIT_MID    17
`define SPB_CE_BIT_HI     19
`define SPB_CE_LO_VAL     1'b1
`define SPB_CE_MID_VAL    1'b0
`define SPB_CE_HI_VAL     1'b0
`define SPB_OFF_W         15

// ============================================================
// register offsets inside the window (byte addresses)
`define SPB_CHAN_BIT      2
`define SPB_CTRL_BIT      3
`define SPB_OFF_DATA_A    15'h0000
`define SPB_OFF_DATA_B    15'h0004
`define SPB_OFF_CTRL_A    15'h0008
`define SPB_OFF_CTRL_B    15'h000C
`define SPB_OFF_BAUD      15'h0010
`define SPB_OFF_CONFIG    15'h0014

// ============================================================
// control write fields, status read fields, config fields
`define SPB_CTL_RTS       0
`define SPB_CTL_DTR       1
`define SPB_CTL_RXIE      2
`define SPB_CTL_ERRCLR    7
`define SPB_ST_RDY        0
`define SPB_ST_TXE        1
`define SPB_ST_CTS        2
`define SPB_ST_DCD        3
`define SPB_ST_OVR        4
`define SPB_ST_FRM        5
`define SPB_CFG_IDX_MAX   4'h9
`define SPB_CFG_FLOW      4
`define SPB_CFG_RST       8'h00
`define SPB_BAUD_RST      4'h0
`define SPB_BAUD_VALID    4

`endif

// [spb_baud_div.v]
// baud rate generator: 16x sample tick from a latched 4-bit select code
`include "spb_map.vh"

module spb_baud_div #(
    parameter CLK_HZ = `SPB_CLK_HZ
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // rate select and external rate clock
    input  wire [3:0] sel,
    input  wire       ext_clk,
    // 16x tick and square wave
    output reg        tick,
    output reg        wave
);

    reg  [`SPB_DIV_W-1:0] cnt_r;
    reg  [3:0]            sel_prev_r;
    reg                   ext_prev_r;
    wire [`SPB_DIV_W-1:0] div;
    wire                  restart;

    // ============================================================
    // divisor: rounded to nearest, worst error 0.147 percent at 4800 and 9600
    function [`SPB_DIV_W-1:0] div_of;
        input [3:0] code;
        integer     rate;
        integer     q;
        begin
            case (code)
                4'h1:    rate = `SPB_BAUD_1;
                4'h2:    rate = `SPB_BAUD_2;
                4'h3:    rate = `SPB_BAUD_3;
                4'h4:    rate = `SPB_BAUD_4;
                4'h5:    rate = `SPB_BAUD_5;
                4'h6:    rate = `SPB_BAUD_6;
                4'h7:    rate = `SPB_BAUD_7;
                4'h8:    rate = `SPB_BAUD_8;
                4'h9:    rate = `SPB_BAUD_9;
                default: rate = `SPB_BAUD_10;
            endcase
            q      = (CLK_HZ + (`SPB_OVS * rate) / 2) / (`SPB_OVS * rate);
            div_of = q[`SPB_DIV_W-1:0];
        end
    endfunction

    assign div = div_of(sel);
    // R05 restart on change
    assign restart = (sel != sel_prev_r);

    // ============================================================
    // R02 synchronous divider
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_r      <= {`SPB_DIV_W{1'b0}};
            sel_prev_r <= `SPB_BAUD_RST;
            ext_prev_r <= 1'b0;
            tick       <= 1'b0;
            wave       <= 1'b0;
        end else begin
            sel_prev_r <= sel;
            ext_prev_r <= ext_clk;
            tick       <= 1'b0;
            if (restart) begin
                cnt_r <= {`SPB_DIV_W{1'b0}};
                wave  <= 1'b0;
            // R03 external rate passed through
            end else if (sel == `SPB_SEL_EXT) begin
                cnt_r <= {`SPB_DIV_W{1'b0}};
                wave  <= ext_clk;
                tick  <= ext_clk & ~ext_prev_r;
            // R05 undefined codes idle
            end else if (sel > `SPB_SEL_MAX) begin
                cnt_r <= {`SPB_DIV_W{1'b0}};
                wave  <= 1'b0;
            // R04 rate codes divide
            end else if (cnt_r == div - 1'b1) begin
                cnt_r <= {`SPB_DIV_W{1'b0}};
                tick  <= 1'b1;
                wave  <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
                if (cnt_r == (div >> 1))
                    wave <= 1'b0;
            end
        end
    end

endmodule // spb_baud_div

// [spb_serial_top.v]
// serial port: baud generator, two-channel async serial controller, apb glue
// Summary of operation
// R01: processor writes 4-bit rate code, latched, chooses bit rate.
// R02: synchronous counters make 16x sample clock within 0.2 percent.
// R03: code 0 passes external clock; codes 1-5 give 75 to 300 baud.
// R04: codes 6-10 give 600 to 9600 baud at 16x.
// R05: codes 11-15 idle the output; divider restarts on code change.
// R06: channel A rx/tx clocks and channel B shared clock from generator.
// R07: two independent async channels, serial to parallel and back.
// R08: each channel also handles modem control lines.
// R09: address bit 1 picks channel, high is B; the code decodes PADDR bit 2.
// R10: address bit 2 high selects control, low selects data; the code uses PADDR bit 3.
// R11: chip enable decoded from address bits 15, 17 and 19.
// R12: when enabled, writes take data or commands, reads return data.
// R13: read strobe active only with bit 19 low and read direction.
// R14: chain-in and first-cycle inputs are held high by the board.
// R15: controller drives its interrupt output low to request service.
// R16: serial interrupt goes to priority level input bit one.
// R17: internal signals positive true; line pins are inverted.
// R18: ten exclusive configurations; rate and handshake kept stored.
`include "spb_map.vh"

module spb_serial_top #(
    parameter CLK_HZ = `SPB_CLK_HZ
) (
    // clock and reset
    input  wire                   MCLK,
    input  wire                   RSTN,
    // apb slave
    input  wire                   PSEL,
    input  wire                   PENABLE,
    input  wire                   PWRITE,
    input  wire [`SPB_ADDR_W-1:0] PADDR,
    input  wire [31:0]            PWDATA,
    output reg  [31:0]            PRDATA,
    output wire                   PREADY,
    output wire                   PSLVERR,
    // external rate clock and generated clocks
    input  wire                   EXT_BAUD_CLK,
    output wire                   CHAN_A_RX_CLOCK,
    output wire                   CHAN_A_TX_CLOCK,
    output wire                   CHAN_B_SHARED_CLOCK,
    // serial lines, index 0 is channel A, index 1 channel B
    output wire [1:0]             TXD_N,
    input  wire [1:0]             RXD_N,
    output wire [1:0]             RTS_N,
    output wire [1:0]             DTR_N,
    input  wire [1:0]             CTS_N,
    input  wire [1:0]             DCD_N,
    // interrupt chain and request
    input  wire                   IRQ_CHAIN_IN,
    input  wire                   FIRST_CYCLE_MARKER,
    output reg                    SERIAL_IRQ_N,
    output reg                    PRIORITY_LEVEL_BIT_ONE_N
);

    localparam RX_IDLE  = 2'b00;
    localparam RX_START = 2'b01;
    localparam RX_DATA  = 2'b10;
    localparam RX_STOP  = 2'b11;

    reg  [3:0]             baud_sel_r;
    reg  [7:0]             config_r;
    wire                   tick;
    wire                   wave;
    wire                   chip_en;
    wire                   rd_strobe_n;
    wire [`SPB_OFF_W-1:0]  off;
    wire                   mapped;
    wire                   acc;
    wire                   wr_acc;
    wire                   rd_acc;
    wire [15:0]            ch_rdata;
    wire [15:0]            ch_status;
    wire [1:0]             ch_irq;
    reg  [31:0]            prdata_nxt;

    // ============================================================
    // R11 chip enable window
    assign chip_en = (PADDR[`SPB_CE_BIT_LO] == `SPB_CE_LO_VAL)
                   & (PADDR[`SPB_CE_BIT_MID] == `SPB_CE_MID_VAL)
                   & (PADDR[`SPB_CE_BIT_HI] == `SPB_CE_HI_VAL);
    // R13 read strobe from bit 19 and direction
    assign rd_strobe_n = ~(PSEL & ~PWRITE & ~PADDR[`SPB_CE_BIT_HI]);
    assign off     = PADDR[`SPB_OFF_W-1:0];
    assign mapped  = chip_en & ((off == `SPB_OFF_DATA_A) | (off == `SPB_OFF_DATA_B)
                   | (off == `SPB_OFF_CTRL_A) | (off == `SPB_OFF_CTRL_B)
                   | (off == `SPB_OFF_BAUD) | (off == `SPB_OFF_CONFIG));
    // zero wait states: access phase always completes
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign acc     = PSEL & PENABLE & mapped;
    // R12 writes and reads only when enabled
    assign wr_acc  = acc & PWRITE;
    assign rd_acc  = acc & ~rd_strobe_n;

    // ============================================================
    // R01 rate code latch, R18 stored configuration
    always @(posedge MCLK) begin
        if (!RSTN) begin
            baud_sel_r <= `SPB_BAUD_RST;
            config_r   <= `SPB_CFG_RST;
        end else if (wr_acc) begin
            if (off == `SPB_OFF_BAUD)
                baud_sel_r <= PWDATA[3:0];
            // R18 only the ten configurations are accepted
            if ((off == `SPB_OFF_CONFIG) && (PWDATA[3:0] <= `SPB_CFG_IDX_MAX))
                config_r <= PWDATA[7:0];
        end
    end

    spb_baud_div #(
        .CLK_HZ (CLK_HZ)
    ) u_div (
        .clk     (MCLK),
        .rst_n   (RSTN),
        .sel     (baud_sel_r),
        .ext_clk (EXT_BAUD_CLK),
        .tick    (tick),
        .wave    (wave)
    );

    // R06 all channel clocks from generator
    assign CHAN_A_RX_CLOCK     = wave;
    assign CHAN_A_TX_CLOCK     = wave;
    assign CHAN_B_SHARED_CLOCK = wave;

    // ============================================================
    // R07 two independent channels
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : ch
            reg  [1:0] rx_st_r;
            reg  [3:0] rx_cnt_r;
            reg  [2:0] rx_bit_r;
            reg  [7:0] rx_sh_r;
            reg  [7:0] rx_data_r;
            reg        rx_rdy_r;
            reg        ovr_r;
            reg        frm_r;
            reg  [7:0] tx_hold_r;
            reg        tx_full_r;
            reg        tx_busy_r;
            reg  [9:0] tx_sh_r;
            reg  [3:0] tx_cnt_r;
            reg  [3:0] tx_bit_r;
            reg        txd_r;
            reg        rts_r;
            reg        dtr_r;
            reg        rxie_r;
            wire       rx_line;
            wire       cts;
            wire       dcd;
            wire       sel_data;
            wire       sel_ctrl;
            wire       rx_done;
            wire       rx_clr;
            wire       err_clr;

            // R17 inverting receivers
            assign rx_line  = ~RXD_N[g];
            assign cts      = ~CTS_N[g];
            assign dcd      = ~DCD_N[g];
            // R09 channel bit, R10 control or data bit
            assign sel_data = (off[`SPB_CHAN_BIT] == g) & ~off[`SPB_CTRL_BIT] & (off < `SPB_OFF_BAUD);
            assign sel_ctrl = (off[`SPB_CHAN_BIT] == g) & off[`SPB_CTRL_BIT] & (off < `SPB_OFF_BAUD);
            assign rx_done  = tick & (rx_st_r == RX_STOP) & (rx_cnt_r == `SPB_TICK_LAST) & rx_line;
            assign rx_clr   = rd_acc & sel_data;
            assign err_clr  = wr_acc & sel_ctrl & PWDATA[`SPB_CTL_ERRCLR];

            // receiver: start bit checked at mid-bit, then one sample per bit
            always @(posedge MCLK) begin
                if (!RSTN) begin
                    rx_st_r   <= RX_IDLE;
                    rx_cnt_r  <= 4'h0;
                    rx_bit_r  <= 3'h0;
                    rx_sh_r   <= 8'h00;
                    rx_data_r <= 8'h00;
                    rx_rdy_r  <= 1'b0;
                    ovr_r     <= 1'b0;
                    frm_r     <= 1'b0;
                end else begin
                    // set wins over a clear in the same cycle
                    if (rx_done)
                        rx_rdy_r <= 1'b1;
                    else if (rx_clr)
                        rx_rdy_r <= 1'b0;
                    if (rx_done && rx_rdy_r && !rx_clr)
                        ovr_r <= 1'b1;
                    else if (err_clr)
                        ovr_r <= 1'b0;
                    if (tick && (rx_st_r == RX_STOP) && (rx_cnt_r == `SPB_TICK_LAST) && !rx_line)
                        frm_r <= 1'b1;
                    else if (err_clr)
                        frm_r <= 1'b0;
                    if (rx_done)
                        rx_data_r <= rx_sh_r;
                    if (tick) begin
                        rx_cnt_r <= rx_cnt_r + 1'b1;
                        case (rx_st_r)
                            RX_IDLE: begin
                                rx_cnt_r <= 4'h0;
                                if (!rx_line)
                                    rx_st_r <= RX_START;
                            end
                            RX_START: begin
                                if (rx_cnt_r == `SPB_TICK_HALF) begin
                                    rx_cnt_r <= 4'h0;
                                    rx_bit_r <= 3'h0;
                                    rx_st_r  <= rx_line ? RX_IDLE : RX_DATA;
                                end
                            end
                            RX_DATA: begin
                                if (rx_cnt_r == `SPB_TICK_LAST) begin
                                    rx_sh_r  <= {rx_line, rx_sh_r[7:1]};
                                    rx_bit_r <= rx_bit_r + 1'b1;
                                    if (rx_bit_r == 3'h7)
                                        rx_st_r <= RX_STOP;
                                end
                            end
                            RX_STOP: begin
                                if (rx_cnt_r == `SPB_TICK_LAST)
                                    rx_st_r <= RX_IDLE;
                            end
                            default: rx_st_r <= RX_IDLE;
                        endcase
                    end
                end
            end

            // transmitter, 8 data bits, 1 stop, lsb first; flow waits for cts
            always @(posedge MCLK) begin
                if (!RSTN) begin
                    tx_hold_r <= 8'h00;
                    tx_full_r <= 1'b0;
                    tx_busy_r <= 1'b0;
                    tx_sh_r   <= 10'h3FF;
                    tx_cnt_r  <= 4'h0;
                    tx_bit_r  <= 4'h0;
                    txd_r     <= 1'b1;
                end else begin
                    // a write while the holding register is full is dropped
                    if (wr_acc && sel_data && !tx_full_r) begin
                        tx_hold_r <= PWDATA[7:0];
                        tx_full_r <= 1'b1;
                    end
                    if (!tx_busy_r && tx_full_r && (cts || !config_r[`SPB_CFG_FLOW])) begin
                        tx_sh_r   <= {1'b1, tx_hold_r, 1'b0};
                        tx_full_r <= 1'b0;
                        tx_busy_r <= 1'b1;
                        tx_cnt_r  <= 4'h0;
                        tx_bit_r  <= 4'h0;
                    end else if (tx_busy_r && tick) begin
                        tx_cnt_r <= tx_cnt_r + 1'b1;
                        if (tx_cnt_r == `SPB_TICK_LAST) begin
                            tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
                            tx_bit_r <= tx_bit_r + 1'b1;
                            if (tx_bit_r == 4'h9)
                                tx_busy_r <= 1'b0;
                        end
                    end
                    txd_r <= tx_busy_r ? tx_sh_r[0] : 1'b1;
                end
            end

            // R08 modem control and interrupt enable
            always @(posedge MCLK) begin
                if (!RSTN) begin
                    rts_r  <= 1'b0;
                    dtr_r  <= 1'b0;
                    rxie_r <= 1'b0;
                end else if (wr_acc && sel_ctrl) begin
                    rts_r  <= PWDATA[`SPB_CTL_RTS];
                    dtr_r  <= PWDATA[`SPB_CTL_DTR];
                    rxie_r <= PWDATA[`SPB_CTL_RXIE];
                end
            end

            // R17 inverting drivers
            assign TXD_N[g] = ~txd_r;
            assign RTS_N[g] = ~rts_r;
            assign DTR_N[g] = ~dtr_r;
            assign ch_rdata[g*8 +: 8]  = rx_data_r;
            assign ch_status[g*8 +: 8] = {2'b00, frm_r, ovr_r, dcd, cts,
                                          ~tx_full_r & ~tx_busy_r, rx_rdy_r};
            assign ch_irq[g] = rx_rdy_r & rxie_r;
        end
    endgenerate

    // ============================================================
    // read data: registered in the setup phase, stable in the access phase
    always @* begin
        prdata_nxt = 32'h0000_0000;
        case (off)
            `SPB_OFF_DATA_A: prdata_nxt[7:0] = ch_rdata[7:0];
            `SPB_OFF_DATA_B: prdata_nxt[7:0] = ch_rdata[15:8];
            `SPB_OFF_CTRL_A: prdata_nxt[7:0] = ch_status[7:0];
            `SPB_OFF_CTRL_B: prdata_nxt[7:0] = ch_status[15:8];
            `SPB_OFF_BAUD: begin
                prdata_nxt[3:0]             = baud_sel_r;
                prdata_nxt[`SPB_BAUD_VALID] = (baud_sel_r <= `SPB_SEL_MAX);
            end
            `SPB_OFF_CONFIG: prdata_nxt[7:0] = config_r;
            default:         prdata_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge MCLK) begin
        if (!RSTN)
            PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !rd_strobe_n && chip_en)
            PRDATA <= prdata_nxt;
    end

    // ============================================================
    // R15 active-low request, R16 routed to level bit one
    always @(posedge MCLK) begin
        if (!RSTN) begin
            SERIAL_IRQ_N             <= 1'b1;
            PRIORITY_LEVEL_BIT_ONE_N <= 1'b1;
        end else begin
            // R14 chain inputs held high by the board gate the request
            SERIAL_IRQ_N             <= ~(|ch_irq & IRQ_CHAIN_IN & FIRST_CYCLE_MARKER);
            PRIORITY_LEVEL_BIT_ONE_N <= ~(|ch_irq & IRQ_CHAIN_IN & FIRST_CYCLE_MARKER);
        end
    end

endmodule // spb_serial_top

// [spb_serial_top_properties.sv]
// concurrent checks on the serial port top, attached by bind
module spb_serial_props #(
    parameter CLK_HZ = 25000000
) (
    // clock and reset
    input wire logic        MCLK,
    input wire logic        RSTN,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [19:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // rate clocks and interrupt
    input wire logic        EXT_BAUD_CLK,
    input wire logic        CHAN_A_RX_CLOCK,
    input wire logic        CHAN_A_TX_CLOCK,
    input wire logic        CHAN_B_SHARED_CLOCK,
    input wire logic        SERIAL_IRQ_N,
    input wire logic        PRIORITY_LEVEL_BIT_ONE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    // divider length at 9600 baud, rounded as the design does
    localparam int DIV = (CLK_HZ + 76800) / 153600;
    logic       acc;
    logic       mapped;
    logic [3:0] code_r;
    logic [7:0] age_r;
    // ============================================================
    // shadow of the rate code, so rate checks need no internal probe
    assign acc = PSEL && PENABLE;
    assign mapped = PADDR[15] && !PADDR[17] && !PADDR[19] && PADDR[14:0] <= 15'h0014 && PADDR[1:0] == 2'h0;
    // age restarts on any rate write
    always @(posedge MCLK) begin
        if (!RSTN) begin
            code_r <= 4'h0;
            age_r  <= 8'h00;
        end else if (acc && PWRITE && mapped && PADDR[14:0] == 15'h0010) begin
            code_r <= PWDATA[3:0];
            age_r  <= 8'h00;
        end else if (age_r != 8'hFF) begin
            age_r <= age_r + 8'h01;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // ============================================================
    // bus decode, rate and interrupt outputs
    a_ready_no_wait: assert property (acc |-> PREADY)
        else $error("access phase without ready");
    a_err_outside: assert property (acc && !mapped |-> PSLVERR)
        else $error("unmapped access not refused");
    a_err_inside: assert property (acc && mapped |-> !PSLVERR)
        else $error("mapped access refused");
    a_clocks_tied: assert property (CHAN_A_TX_CLOCK == CHAN_A_RX_CLOCK && CHAN_B_SHARED_CLOCK == CHAN_A_RX_CLOCK)
        else $error("channel clocks differ");
    a_irq_mirror: assert property (SERIAL_IRQ_N == PRIORITY_LEVEL_BIT_ONE_N)
        else $error("priority bit differs from serial request");
    a_idle_code: assert property ((code_r > 4'hA) [*3] |-> !CHAN_A_RX_CLOCK)
        else $error("rate clock runs on undefined code");
    a_ext_follow: assert property ((code_r == 4'h0) [*4] |-> CHAN_A_RX_CLOCK == $past(EXT_BAUD_CLK))
        else $error("external rate clock not passed through");
    a_tick_period: assert property ($rose(CHAN_A_RX_CLOCK) && code_r == 4'hA && age_r > 8'h28 |-> $past(CHAN_A_RX_CLOCK, DIV))
        else $error("sample tick period wrong");
    cover property ($fell(SERIAL_IRQ_N));
    cover property (acc && PSLVERR);
    cover property ($rose(CHAN_A_RX_CLOCK) && code_r == 4'hA && age_r > 8'h28);
endmodule // spb_serial_props

bind spb_serial_top spb_serial_props #(.CLK_HZ(CLK_HZ)) spb_serial_props_i (
    .MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_BAUD_CLK(EXT_BAUD_CLK),
    .CHAN_A_RX_CLOCK(CHAN_A_RX_CLOCK), .CHAN_A_TX_CLOCK(CHAN_A_TX_CLOCK),
    .CHAN_B_SHARED_CLOCK(CHAN_B_SHARED_CLOCK), .SERIAL_IRQ_N(SERIAL_IRQ_N),
    .PRIORITY_LEVEL_BIT_ONE_N(PRIORITY_LEVEL_BIT_ONE_N)
);

// [spb_host_model.sv]
// far-end serial host: frames bytes on the inverted line pins
module spb_host_model #(
    parameter int BIT = 256
) (
    // clock
    input wire logic       clk,
    // line pins, index 0 is channel A
    input wire logic [1:0] txd_n,
    output logic     [1:0] rxd_n,
    output logic     [1:0] cts_n,
    output logic     [1:0] dcd_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // line idles at mark (pin low); clear to send on both, carrier on A only
    initial begin
        rxd_n = 2'b00;
        cts_n = 2'b00;
        dcd_n = 2'b10;
    end
    // inverted frame: start high at the pin, lsb first, stop low
    task automatic send(input int ch, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd_n[ch] <= ~f[i];
            repeat (BIT - 1) @(posedge clk);
        end
    endtask
    // sample mid bit; a missing stop bit poisons the byte
    task automatic recv(input int ch, output logic [7:0] b);
        wait (txd_n[ch] === 1'b1);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = ~txd_n[ch];
        end
        repeat (BIT) @(posedge clk);
        if (txd_n[ch] !== 1'b0) b = 8'hXX;
    endtask
endmodule // spb_host_model

// [tb_serial_port_baud_and_uart_glue.sv]
// self-checking bench for the serial port block with a far-end host
module tb_serial_port_baud_and_uart_glue;
    timeunit 1ns;
    timeprecision 1ps;
    // slow board clock value so 9600 baud is 16 cycles a tick, 256 a bit
    localparam int          CLK_HZ = 2457600;
    localparam logic [19:0] DAT_A  = 20'h08000;
    localparam logic [19:0] DAT_B  = 20'h08004;
    localparam logic [19:0] CTL_A  = 20'h08008;
    localparam logic [19:0] CTL_B  = 20'h0800C;
    localparam logic [19:0] RATE   = 20'h08010;
    logic        mclk, rstn, psel, penable, pwrite, ext_clk, pready, pslverr, er;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  txd_n, rxd_n, rts_n, dtr_n, cts_n, dcd_n;
    logic        clk_a_rx, clk_a_tx, clk_b, irq_n, lvl1_n;
    logic [7:0]  got;
    int          err_count, n_tests, cyc;
    // chain-in and first-cycle held high as on the board
    spb_serial_top #(.CLK_HZ(CLK_HZ)) spb_serial_top_i (
        .MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_BAUD_CLK(ext_clk),
        .CHAN_A_RX_CLOCK(clk_a_rx), .CHAN_A_TX_CLOCK(clk_a_tx), .CHAN_B_SHARED_CLOCK(clk_b),
        .TXD_N(txd_n), .RXD_N(rxd_n), .RTS_N(rts_n), .DTR_N(dtr_n), .CTS_N(cts_n), .DCD_N(dcd_n),
        .IRQ_CHAIN_IN(1'b1), .FIRST_CYCLE_MARKER(1'b1), .SERIAL_IRQ_N(irq_n), .PRIORITY_LEVEL_BIT_ONE_N(lvl1_n)
    );
    spb_host_model #(.BIT(256)) spb_host_model_i (
        .clk(mclk), .txd_n(txd_n), .rxd_n(rxd_n), .cts_n(cts_n), .dcd_n(dcd_n)
    );
    // ============================================================
    // clock, external rate clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) ext_clk <= ~ext_clk;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    // ============================================================
    // compare, apb transfer and verdict
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // request held until ready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [19:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [19:0] a, input logic [31:0] e, input logic ee);
        xfer(1'b0, a, 8'h00);
        check(rd, e);
        check(er, ee);
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
        check(er, 0);
    endtask
    task automatic conclude();
        if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ============================================================
    // main sequence
    initial begin
        {rstn, psel, penable, pwrite, ext_clk, paddr, pwdata} = '0;
        {cyc, err_count, n_tests} = '0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        check({txd_n, rts_n, dtr_n, irq_n, lvl1_n}, 32'h3F);
        rdc(RATE, 32'h10, 0);
        rdc(CTL_A, 32'h0E, 0);
        rdc(CTL_B, 32'h06, 0);
        rdc(20'h00010, rd, 1);
        rdc(20'h88010, rd, 1);
        rdc(20'h08018, 32'h0, 1);
        xfer(1'b1, 20'h00010, 8'h05);
        check(er, 1);
        rdc(RATE, 32'h10, 0);
        for (int c = 1; c < 16; c++) begin
            wr(RATE, 8'(c));
            rdc(RATE, {27'h0, c <= 10, 4'(c)}, 0);
        end
        wr(RATE, 8'h0A);
        wr(CTL_A, 8'h03);
        @(posedge mclk);
        check({rts_n, dtr_n}, 32'hA);
        fork
            spb_host_model_i.recv(0, got);
            wr(DAT_A, 8'hA5);
        join
        check(got, 32'hA5);
        wr(CTL_B, 8'h04);
        spb_host_model_i.send(1, 8'h3C);
        for (int i = 0; i < 400 && irq_n !== 1'b0; i++) @(posedge mclk);
        check({irq_n, lvl1_n}, 0);
        rdc(CTL_B, 32'h07, 0);
        rdc(DAT_B, 32'h3C, 0);
        repeat (2) @(posedge mclk);
        check(irq_n, 1);
        conclude();
    end
endmodule // tb_serial_port_baud_and_uart_glue
